// ===== hbd_top.sv
`include "hbd_params.svh"

module hbd_top #(
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic busClk,
	input hbd_pkg::hbd_bus_s busIn,
	output hbd_pkg::hbd_pin_s [`HBD_DATA_W-1:0] busData,
	output logic [31:0] busDataOut,
	output logic busDataOe,
	input wire logic [1:0] controllerNum,
	input wire logic readyTristatePin,
	input wire logic readyInvertPin,
	input hbd_pkg::hbd_cfg_s cfg,
	input hbd_pkg::hbd_win_s window0,
	input hbd_pkg::hbd_win_s window1,
	input wire logic [31:0] flagSetIn,
	input wire logic [31:0] outFifoData,
	input wire logic [31:0] extReadData,
	input wire logic extReadAck,
	input wire logic dmaWantIn,
	input wire logic dmaStopIn,
	input wire logic dmaAcknowledgeIn,
	output hbd_pkg::hbd_pin_s dmaRequestOut,
	output hbd_pkg::hbd_pin_s dmaStopOut,
	output hbd_pkg::hbd_pin_s interruptRequestOut,
	output hbd_pkg::hbd_pin_s busReadyOut,
	output hbd_pkg::hbd_hit_e hitOut,
	output logic [31:0] writeData,
	output logic commandWe,
	output logic inFifoWe,
	output logic outFifoRe,
	output logic extWe,
	output logic [31:0] flagsOut,
	output logic [31:0] maskOut
);
	import hbd_pkg::*;

	localparam int SYNC_W = $bits(hbd_bus_s) + 6;

	hbd_state_s st_q;
	hbd_state_s st_d;
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	hbd_bus_s busSync;
	logic busClkSync;
	logic ackSync;
	logic [1:0] cnumSync;
	logic rdyTriSync;
	logic rdyInvSync;
	logic busEdge;
	logic readNow;
	logic writeNow;
	hbd_hit_e hitNow;
	logic [`HBD_OFS_W-1:0] ofs;
	logic cause;
	logic [`HBD_DATA_W-1:0] flagsSw;
	logic [`HBD_DATA_W-1:0] maskSw;
	logic selTriDr;
	logic selInvDr;
	logic selTriDs;
	logic selInvDs;
	logic selTriIrq;
	logic selInvIrq;

	// ============================================================
	// pin synchronisers
	assign syncIn = {busIn, busClk, dmaAcknowledgeIn, controllerNum,
		readyTristatePin, readyInvertPin};

	hbd_sync2 #(
		.WIDTH(SYNC_W)
	) u_pinSync (
		.clk(clk),
		.reset(reset),
		.din(syncIn),
		.dout(syncOut)
	);

	assign {busSync, busClkSync, ackSync, cnumSync, rdyTriSync,
		rdyInvSync} = syncOut;
	assign busEdge = busClkSync & ~st_q.busClkPrev;

	// ============================================================
	// address decoder
	function automatic hbd_hit_e decode(
		input logic [`HBD_ADDR_W-1:0] a,
		input logic [1:0] cnum,
		input hbd_win_s w0,
		input hbd_win_s w1
	);
		logic [`HBD_OFS_W-1:0] o;
		logic [`HBD_ADDR_W:0] end0;
		logic [`HBD_ADDR_W:0] end1;
		o = a[`HBD_OFS_W-1:0];
		end0 = {1'b0, w0.base} + {1'b0, w0.size};
		end1 = {1'b0, w1.base} + {1'b0, w1.size};
		if (a[20:18] == 3'h0) begin
			if (a[17:16] != cnum) begin
				decode = HBD_HIT_EMPTY;
			end else if (o < `HBD_OFS_REG_END) begin
				decode = HBD_HIT_REG;
			end else if (o >= `HBD_RSV_LO && o <= `HBD_CU_HI) begin
				decode = HBD_HIT_CU;
			end else if (o >= `HBD_SPD_LO && o <= `HBD_SPD_HI) begin
				decode = HBD_HIT_SPD;
			end else if (o >= `HBD_RSV_LO) begin
				decode = HBD_HIT_EMPTY;
			end else begin
				decode = HBD_HIT_CTRL;
			end
		end else if (w1.enable && {1'b0, a} >= {1'b0, w1.base} &&
				{1'b0, a} < end1) begin
			decode = HBD_HIT_WIN1;
		end else if (w0.enable && {1'b0, a} >= {1'b0, w0.base} &&
				{1'b0, a} < end0) begin
			decode = HBD_HIT_WIN0;
		end else begin
			decode = HBD_HIT_EMPTY;
		end
	endfunction

	// ============================================================
	// next state
	always_comb begin
		st_d = st_q;
		st_d.busClkPrev = busClkSync;
		st_d.cmdWe = 1'b0;
		st_d.inFifoWe = 1'b0;
		st_d.outFifoRe = 1'b0;
		st_d.extWe = 1'b0;

		// sample point 1, then core resample
		if (busEdge) begin
			st_d.cap = busSync;
		end
		st_d.rs = st_q.cap;

		readNow = ~st_q.rs.csN & ~st_q.rs.rdN;
		writeNow = ~st_q.rs.csN & ~st_q.rs.wrN & ~readNow;
		hitNow = decode(st_q.rs.addr, cnumSync, window0, window1);
		ofs = st_q.rs.addr[`HBD_OFS_W-1:0];
		flagsSw = st_q.flags;
		maskSw = st_q.mask;

		// ============================================================
		// read path
		st_d.readActive = readNow;
		if (readNow && !st_q.readActive) begin
			st_d.hit = hitNow;
			st_d.dataOe = (hitNow != HBD_HIT_EMPTY);
			st_d.ready = (hitNow == HBD_HIT_REG) ||
				(hitNow == HBD_HIT_EMPTY);
			st_d.rdata = `HBD_DATA_RESET;
			if (hitNow == HBD_HIT_REG) begin
				if (ofs == `HBD_OFS_OUT_FIFO) begin
					st_d.rdata = outFifoData;
					st_d.outFifoRe = 1'b1;
				end else if (ofs == `HBD_OFS_FLAG) begin
					st_d.rdata = st_q.flags;
				end else if (ofs == `HBD_OFS_MASK) begin
					st_d.rdata = st_q.mask;
				end
			end
		end else if (readNow) begin
			if (!st_q.ready && extReadAck) begin
				st_d.rdata = extReadData;
				st_d.ready = 1'b1;
			end
		end else begin
			st_d.dataOe = 1'b0;
			st_d.ready = 1'b0;
		end

		// ============================================================
		// write path
		st_d.writeActive = writeNow;
		if (writeNow && !st_q.writeActive) begin
			st_d.hit = hitNow;
			if (hitNow == HBD_HIT_REG) begin
				if (ofs == `HBD_OFS_COMMAND) begin
					st_d.cmdWe = 1'b1;
				end else if (ofs == `HBD_OFS_IN_FIFO) begin
					st_d.inFifoWe = 1'b1;
				end else if (ofs == `HBD_OFS_FLAG) begin
					flagsSw = st_q.rs.wdata;
				end else if (ofs == `HBD_OFS_FLAG_CLR) begin
					flagsSw = st_q.flags & ~st_q.rs.wdata;
				end else if (ofs == `HBD_OFS_FLAG_SET) begin
					flagsSw = st_q.flags | st_q.rs.wdata;
				end else if (ofs == `HBD_OFS_MASK) begin
					maskSw = st_q.rs.wdata;
				end else if (ofs == `HBD_OFS_MASK_CLR) begin
					maskSw = st_q.mask & ~st_q.rs.wdata;
				end else if (ofs == `HBD_OFS_MASK_SET) begin
					maskSw = st_q.mask | st_q.rs.wdata;
				end
			end else if (hitNow != HBD_HIT_EMPTY) begin
				st_d.extWe = 1'b1;
			end
		end
		// hardware set wins over a software clear
		st_d.flags = flagsSw | flagSetIn;
		st_d.mask = maskSw;

		// ============================================================
		// interrupt request in core domain
		cause = |(st_q.flags & st_q.mask);
		st_d.causePrev = cause;
		if (FULL_VARIANT && cfg.irqEdgeMode) begin
			if (cause && !st_q.causePrev) begin
				st_d.pulseCnt = cfg.pulseLen;
			end else if (st_q.pulseCnt != '0) begin
				st_d.pulseCnt = st_q.pulseCnt - 1'b1;
			end
			st_d.irqCore = (st_d.pulseCnt != '0);
		end else begin
			st_d.pulseCnt = '0;
			st_d.irqCore = cause;
		end

		// ============================================================
		// bus stage outputs
		if (busEdge) begin
			st_d.irqBus = st_q.irqCore;
			st_d.dmaReqBus = dmaWantIn & ~ackSync;
			st_d.dmaStopBus = dmaStopIn;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
			st_q.cap.csN <= 1'b1;
			st_q.cap.rdN <= 1'b1;
			st_q.cap.wrN <= 1'b1;
			st_q.rs.csN <= 1'b1;
			st_q.rs.rdN <= 1'b1;
			st_q.rs.wrN <= 1'b1;
			st_q.hit <= HBD_HIT_EMPTY;
			st_q.flags <= `HBD_FLAG_RESET;
			st_q.mask <= `HBD_MASK_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ============================================================
	// output configuration
	assign selTriDr = FULL_VARIANT ? cfg.drTri : cfg.sharedTri;
	assign selInvDr = FULL_VARIANT ? cfg.drInv : cfg.sharedInv;
	assign selTriDs = FULL_VARIANT ? cfg.dsTri : cfg.sharedTri;
	assign selInvDs = FULL_VARIANT ? cfg.dsInv : cfg.sharedInv;
	assign selTriIrq = FULL_VARIANT ? cfg.irqTri : cfg.sharedTri;
	assign selInvIrq = FULL_VARIANT ? cfg.irqInv : cfg.sharedInv;

	hbd_out_cfg u_dmaReqCfg (
		.level(st_q.dmaReqBus),
		.tristate(selTriDr),
		.invert(selInvDr),
		.pin(dmaRequestOut)
	);

	hbd_out_cfg u_dmaStopCfg (
		.level(st_q.dmaStopBus),
		.tristate(selTriDs),
		.invert(selInvDs),
		.pin(dmaStopOut)
	);

	hbd_out_cfg u_irqCfg (
		.level(st_q.irqBus),
		.tristate(selTriIrq),
		.invert(selInvIrq),
		.pin(interruptRequestOut)
	);

	// ready high once chip select is seen high
	hbd_out_cfg u_readyCfg (
		.level(st_q.rs.csN | st_q.ready),
		.tristate(FULL_VARIANT & rdyTriSync),
		.invert(FULL_VARIANT & rdyInvSync),
		.pin(busReadyOut)
	);

	assign busData = '0;
	assign busDataOut = st_q.rdata;
	assign busDataOe = st_q.dataOe & readNow;
	assign hitOut = st_q.hit;
	assign writeData = st_q.rs.wdata;
	assign commandWe = st_q.cmdWe;
	assign inFifoWe = st_q.inFifoWe;
	assign outFifoRe = st_q.outFifoRe;
	assign extWe = st_q.extWe;
	assign flagsOut = st_q.flags;
	assign maskOut = st_q.mask;
endmodule // hbd_top

// ===== hbd_params.svh
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

// ============================================================
// bus widths
`define HBD_ADDR_W 21
`define HBD_DATA_W 32
`define HBD_OFS_W 16
`define HBD_CNUM_W 2
`define HBD_PULSE_W 8

// ============================================================
// register offsets inside the own 64 kByte block
`define HBD_OFS_COMMAND 16'h0000
`define HBD_OFS_IN_FIFO 16'h0004
`define HBD_OFS_OUT_FIFO 16'h0008
`define HBD_OFS_FLAG 16'h000C
`define HBD_OFS_FLAG_CLR 16'h0010
`define HBD_OFS_FLAG_SET 16'h0014
`define HBD_OFS_MASK 16'h0018
`define HBD_OFS_MASK_CLR 16'h001C
`define HBD_OFS_MASK_SET 16'h0020
`define HBD_OFS_REG_END 16'h0024

// ============================================================
// reserved area at the top of the block
`define HBD_RSV_LO 16'hFC00
`define HBD_CU_HI 16'hFC07
`define HBD_SPD_LO 16'hFD00
`define HBD_SPD_HI 16'hFD0F

// ============================================================
// reset values
`define HBD_FLAG_RESET 32'h0000_0000
`define HBD_MASK_RESET 32'h0000_0000
`define HBD_DATA_RESET 32'h0000_0000

`endif

// ===== hbd_pkg.sv
package hbd_pkg;
	`include "hbd_params.svh"

	// ============================================================
	// decode result, in priority order
	typedef enum logic [2:0] {
		HBD_HIT_REG,
		HBD_HIT_CU,
		HBD_HIT_SPD,
		HBD_HIT_CTRL,
		HBD_HIT_EMPTY,
		HBD_HIT_WIN1,
		HBD_HIT_WIN0
	} hbd_hit_e;

	typedef struct packed {
		logic csN;
		logic rdN;
		logic wrN;
		logic [`HBD_ADDR_W-1:0] addr;
		logic [`HBD_DATA_W-1:0] wdata;
	} hbd_bus_s;

	typedef struct packed {
		logic enable;
		logic [`HBD_ADDR_W-1:0] base;
		logic [`HBD_ADDR_W-1:0] size;
	} hbd_win_s;

	typedef struct packed {
		logic drTri;
		logic drInv;
		logic dsTri;
		logic dsInv;
		logic irqTri;
		logic irqInv;
		logic sharedTri;
		logic sharedInv;
		logic irqEdgeMode;
		logic [`HBD_PULSE_W-1:0] pulseLen;
	} hbd_cfg_s;

	typedef struct packed {
		logic out;
		logic oe;
	} hbd_pin_s;

	typedef struct packed {
		logic busClkPrev;
		hbd_bus_s cap;
		hbd_bus_s rs;
		logic readActive;
		logic writeActive;
		hbd_hit_e hit;
		logic [`HBD_DATA_W-1:0] flags;
		logic [`HBD_DATA_W-1:0] mask;
		logic causePrev;
		logic [`HBD_PULSE_W-1:0] pulseCnt;
		logic irqCore;
		logic irqBus;
		logic dmaReqBus;
		logic dmaStopBus;
		logic [`HBD_DATA_W-1:0] rdata;
		logic dataOe;
		logic ready;
		logic cmdWe;
		logic inFifoWe;
		logic outFifoRe;
		logic extWe;
	} hbd_state_s;
endpackage

// ===== hbd_sync2.sv
module hbd_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} hbd_sync_s;

	hbd_sync_s st_q;
	hbd_sync_s st_d;

	always_comb begin
		st_d.meta = din;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.stable;
endmodule // hbd_sync2

// ===== hbd_out_cfg.sv
module hbd_out_cfg (
	input wire logic level,
	input wire logic tristate,
	input wire logic invert,
	output hbd_pkg::hbd_pin_s pin
);
	import hbd_pkg::*;

	logic value;

	// emulated open drain: low always driven, high floated
	always_comb begin
		value = level ^ invert;
		if (tristate) begin
			pin.out = 1'b0;
			pin.oe = ~value;
		end else begin
			pin.out = value;
			pin.oe = 1'b1;
		end
	end
endmodule // hbd_out_cfg

// ===== hbd_top_assertions.sv
module hbd_top_assertions #(
	parameter bit FULL_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input hbd_pkg::hbd_bus_s busIn,
	input wire logic busDataOe,
	input wire logic readyTristatePin,
	input hbd_pkg::hbd_cfg_s cfg,
	input hbd_pkg::hbd_pin_s dmaRequestOut,
	input hbd_pkg::hbd_pin_s dmaStopOut,
	input hbd_pkg::hbd_pin_s interruptRequestOut,
	input hbd_pkg::hbd_pin_s busReadyOut,
	input hbd_pkg::hbd_hit_e hitOut,
	input wire logic commandWe,
	input wire logic inFifoWe,
	input wire logic extWe,
	input wire logic [31:0] flagsOut,
	input wire logic [31:0] maskOut
);
	import hbd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic cause;
	logic [7:0] hiCnt_q;
	// ============================================================
	// helpers
	assign cause = |(flagsOut & maskOut);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hiCnt_q <= 8'h00;
		end else if (!interruptRequestOut.out) begin
			hiCnt_q <= 8'h00;
		end else if (hiCnt_q != 8'hFF) begin
			hiCnt_q <= hiCnt_q + 8'h01;
		end
	end
	sequence sCauseUp;
		$rose(cause) ##0 !(cfg.irqEdgeMode | cfg.irqTri | cfg.irqInv);
	endsequence
	sequence sCauseDown;
		$fell(cause) ##0 !(cfg.irqEdgeMode | cfg.irqTri | cfg.irqInv);
	endsequence
	// ============================================================
	// properties
	a_read_pins: assert property ($rose(busDataOe) |->
		$past(!busIn.csN && !busIn.rdN, 4)) else $error("drive without read");
	a_empty_quiet: assert property (hitOut == HBD_HIT_EMPTY |->
		!busDataOe) else $error("data driven on empty hit");
	a_empty_nowrite: assert property (hitOut == HBD_HIT_EMPTY |->
		!(commandWe | inFifoWe | extWe)) else $error("write on empty hit");
	a_cmd_reg: assert property (commandWe | inFifoWe |->
		hitOut == HBD_HIT_REG) else $error("register write off register hit");
	a_irq_up: assert property (sCauseUp |->
		##[1:40] interruptRequestOut.out) else $error("level request late");
	a_irq_down: assert property (sCauseDown |->
		##[1:40] !interruptRequestOut.out) else $error("level request held");
	a_edge_len: assert property (cfg.irqEdgeMode && !cfg.irqTri
		&& !cfg.irqInv |-> {1'b0, hiCnt_q} <= {1'b0, cfg.pulseLen} + 9'h00C)
		else $error("edge pulse too long");
	a_dma_drain: assert property (FULL_VARIANT && cfg.drTri [*3]
		|-> !dmaRequestOut.out) else $error("request driven high");
	a_stop_drain: assert property (FULL_VARIANT && cfg.dsTri [*3]
		|-> !dmaStopOut.out) else $error("stop driven high");
	a_irq_drain: assert property (FULL_VARIANT && cfg.irqTri [*3]
		|-> !interruptRequestOut.out) else $error("interrupt driven high");
	a_ready_pin: assert property (FULL_VARIANT && readyTristatePin [*4]
		|-> !busReadyOut.out) else $error("ready driven high");
endmodule // hbd_top_assertions

bind hbd_top hbd_top_assertions #(.FULL_VARIANT(FULL_VARIANT)) chk (.clk,
	.reset, .busIn, .busDataOe, .readyTristatePin, .cfg, .dmaRequestOut,
	.dmaStopOut, .interruptRequestOut, .busReadyOut, .hitOut, .commandWe,
	.inFifoWe, .extWe, .flagsOut, .maskOut);

// ===== hbd_mcu_model.sv
module hbd_mcu_model (
	input wire logic clk,
	output logic busClk,
	output hbd_pkg::hbd_bus_s bus,
	output logic dmaAck,
	input wire logic dmaReq,
	input wire logic rdyLevel,
	input wire logic [31:0] dataIn,
	input wire logic dataOe
);
	timeunit 1ns;
	timeprecision 1ps;
	import hbd_pkg::*;
	// ============================================================
	// bus clock slower than core, ack follows request
	initial begin
		busClk = 1'b0;
		bus = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: '0, wdata: '0};
		dmaAck = 1'b0;
	end
	always #10 busClk = ~busClk;
	always @(posedge busClk) dmaAck <= dmaReq;
	task automatic acc(input logic wr, input logic [20:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		bus <= '{csN: 1'b0, rdN: wr, wrN: !wr, addr: a, wdata: d};
		repeat (16) @(posedge clk);
		while (!wr && rdyLevel !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		q = dataOe ? dataIn : ~dataIn;
		bus <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: ~a, wdata: ~d};
		repeat (16) @(posedge clk);
	endtask
endmodule // hbd_mcu_model

// ===== tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hbd_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic busClk;
	hbd_bus_s busIn;
	logic [31:0] busDataOut;
	logic busDataOe;
	logic [1:0] controllerNum = 2'b00;
	logic readyTristatePin = 1'b0;
	logic readyInvertPin = 1'b0;
	hbd_cfg_s cfg = '0;
	hbd_win_s window0 = '0;
	logic [31:0] flagSetIn = 32'h0000_0000;
	logic dmaWantIn = 1'b0;
	logic dmaStopIn = 1'b0;
	logic dmaAck;
	hbd_pin_s dmaRequestOut;
	hbd_pin_s dmaStopOut;
	hbd_pin_s interruptRequestOut;
	hbd_pin_s busReadyOut;
	hbd_hit_e hitOut;
	logic [31:0] flagsOut;
	logic [31:0] maskOut;
	int numErrors = 0;
	int totalChecks = 0;
	always #2.5 clk = ~clk;
	hbd_top uut (.clk, .reset, .busClk, .busIn, .busData(), .busDataOut,
		.busDataOe, .controllerNum, .readyTristatePin, .readyInvertPin,
		.cfg, .window0, .window1('0), .flagSetIn, .outFifoData(32'h0000_0000),
		.extReadData(32'h0000_0000), .extReadAck(1'b0), .dmaWantIn, .dmaStopIn,
		.dmaAcknowledgeIn(dmaAck), .dmaRequestOut, .dmaStopOut,
		.interruptRequestOut, .busReadyOut, .hitOut, .writeData(),
		.commandWe(), .inFifoWe(), .outFifoRe(), .extWe(), .flagsOut, .maskOut);
	hbd_mcu_model mcu (.clk, .busClk, .bus(busIn), .dmaAck,
		.dmaReq(dmaRequestOut.out), .rdyLevel(busReadyOut.out),
		.dataIn(busDataOut), .dataOe(busDataOe));
	// ============================================================
	// shared tasks
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic pinVal(input int sel);
		case (sel)
			0: return interruptRequestOut.out;
			1: return dmaStopOut.out;
			2: return dmaStopOut.oe;
			3: return dmaRequestOut.out;
			5: return busReadyOut.out;
			default: return busReadyOut.oe;
		endcase
	endfunction
	task automatic waitPin(input string name, input int sel, input logic v);
		int n;
		n = 0;
		while (pinVal(sel) !== v && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk(name, {31'h0, pinVal(sel)}, {31'h0, v});
	endtask
	task automatic wr32(input logic [20:0] a, input logic [31:0] d);
		logic [31:0] q;
		mcu.acc(1'b1, a, d, q);
	endtask
	task automatic closeOut;
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ============================================================
	// scenarios
	task automatic tRegs;
		logic [31:0] q;
		chk("flags reset", flagsOut, 32'h0000_0000);
		chk("mask reset", maskOut, 32'h0000_0000);
		wr32(21'h0_0018, 32'h0000_00F0);
		mcu.acc(1'b0, 21'h0_0018, 32'h0000_0000, q);
		chk("mask read", q, 32'h0000_00F0);
		wr32(21'h0_0014, 32'h0000_0011);
		mcu.acc(1'b0, 21'h0_000C, 32'h0000_0000, q);
		chk("flag read", q, 32'h0000_0011);
		waitPin("irq level", 0, 1'b1);
		wr32(21'h0_0000, 32'h1234_5678);
		mcu.acc(1'b0, 21'h0_0000, 32'h0000_0000, q);
		chk("wo read", q, 32'h0000_0000);
		wr32(21'h0_0010, 32'h0000_0010);
		chk("flag clear", flagsOut, 32'h0000_0001);
		waitPin("irq cleared", 0, 1'b0);
	endtask
	task automatic tEdge;
		int n;
		n = 0;
		cfg.irqEdgeMode <= 1'b1;
		cfg.pulseLen <= 8'h10;
		flagSetIn <= 32'h0000_0020;
		@(posedge clk);
		flagSetIn <= 32'h0000_0000;
		waitPin("edge up", 0, 1'b1);
		while (interruptRequestOut.out === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("edge len", 32'(n >= 11 && n <= 20), 32'h0000_0001);
		repeat (40) @(posedge clk);
		chk("one pulse", {31'h0, interruptRequestOut.out}, 32'h0);
		wr32(21'h0_0010, 32'h0000_0020);
		cfg.irqEdgeMode <= 1'b0;
	endtask
	task automatic tDecode;
		logic [31:0] q;
		logic [20:0] ad [4] = '{21'h0_0014, 21'h1_FC10, 21'h4_FFFC, 21'h7_0000};
		hbd_hit_e ht [4] = '{HBD_HIT_EMPTY, HBD_HIT_EMPTY, HBD_HIT_WIN0,
			HBD_HIT_EMPTY};
		controllerNum <= 2'b01;
		window0 <= '{enable: 1'b1, base: 21'h1_0000, size: 21'h4_0000};
		mcu.acc(1'b0, 21'h1_000C, 32'h0000_0000, q);
		chk("own block", q, 32'h0000_0001);
		chk("own hit", 32'(hitOut), 32'(HBD_HIT_REG));
		for (int i = 0; i < 4; i++) begin
			wr32(ad[i], 32'h0000_0100);
			chk("hit", 32'(hitOut), 32'(ht[i]));
		end
		chk("flags kept", flagsOut, 32'h0000_0001);
	endtask
	task automatic tOuts;
		dmaStopIn <= 1'b1;
		dmaWantIn <= 1'b1;
		waitPin("stop", 1, 1'b1);
		waitPin("request", 3, 1'b1);
		cfg.dsInv <= 1'b1;
		waitPin("stop inverted", 1, 1'b0);
		cfg.dsInv <= 1'b0;
		cfg.dsTri <= 1'b1;
		cfg.irqTri <= 1'b1;
		waitPin("stop floats", 2, 1'b0);
		dmaStopIn <= 1'b0;
		waitPin("stop drives low", 2, 1'b1);
		readyInvertPin <= 1'b1;
		waitPin("ready inverted", 5, 1'b0);
		readyInvertPin <= 1'b0;
		readyTristatePin <= 1'b1;
		waitPin("ready floats", 4, 1'b0);
	endtask
	initial begin
		#20000;
		numErrors++;
		closeOut;
	end
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		tRegs;
		tEdge;
		tDecode;
		tOuts;
		closeOut;
	end
endmodule // tb
